// ### sim/sio_bus_ctrl_chk.sv
// Port checker for the serial I/O shift bus controller.
// Assumes it is bound into sio_bus_ctrl and sees only its ports.
`default_nettype none

module sio_bus_ctrl_chk (
    // Clock, reset and requests
    input wire logic core_clk, rst, cycle_req, tc_req, ir_req,
    input wire logic int_out_req, img_rd,
    // Status and chain pins
    input wire logic cycle_busy, cycle_done, int_out_pending, stop_mode,
    input wire logic io_not_ready_flag, bus_fault, img_rvalid,
    input wire logic bus_clk, bus_load, bus_strobe,
    input wire logic [1:0] cycle_kind
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [9:0] ld_cnt;
    logic [9:0] hi_cnt;

    // Lengths of the load pulse and of the high half of a bit.
    always_ff @(posedge core_clk) begin
        ld_cnt <= (rst || !bus_load) ? 10'h000 : ld_cnt + 10'h001;
        hi_cnt <= (rst || !bus_clk) ? 10'h000 : hi_cnt + 10'h001;
    end

    property p_load_len;
        $fell(bus_load) |-> ld_cnt == 10'h1F4;
    endproperty
    a_load_len: assert property (p_load_len)
        else $error("load pulse not one bit time");
    property p_clk_half;
        $fell(bus_clk) |-> hi_cnt == 10'h0FA;
    endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("bit clock high half wrong");
    property p_start;
        !cycle_busy && !cycle_done && (cycle_req || tc_req || ir_req)
            |=> cycle_busy;
    endproperty
    a_start: assert property (p_start)
        else $error("request not taken");
    property p_rvalid;
        img_rd |=> img_rvalid;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer missing");
    property p_done;
        cycle_done |=> !cycle_done && !cycle_busy;
    endproperty
    a_done: assert property (p_done)
        else $error("done not a single pulse");
    property p_fault;
        bus_fault |-> $past(cycle_done);
    endproperty
    a_fault: assert property (p_fault)
        else $error("fault not after done");
    property p_no_strobe;
        $rose(bus_strobe) |-> cycle_kind == 2'h0 || cycle_kind == 2'h3;
    endproperty
    a_no_strobe: assert property (p_no_strobe)
        else $error("strobe in interrupt input cycle");
    property p_int_out;
        int_out_req && !int_out_pending && !cycle_busy && !cycle_req
            && !tc_req && !ir_req |=> !cycle_busy;
    endproperty
    a_int_out: assert property (p_int_out)
        else $error("output cycle without pending data");
    property p_stop;
        stop_mode |=> stop_mode && io_not_ready_flag && cycle_busy
            && $stable(bus_clk) && !bus_load;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop mode not held");
    c_fault: cover property (bus_fault);
    c_stop: cover property ($rose(stop_mode));
    c_int_out: cover property (cycle_done && cycle_kind == 2'h3);
endmodule : sio_bus_ctrl_chk

bind sio_bus_ctrl sio_bus_ctrl_chk u_chk (.*);

`default_nettype wire

// ### sim/sio_chain_model.sv
// Chain of module shift registers on the far side of the bus.
// Assumes the controller drives the bit clock, load and strobe.
`default_nettype none

module sio_chain_model #(
    parameter int L = 32
) (
    // Chain pins
    input wire logic bus_clk, bus_dout, bus_chk_out, bus_load, bus_strobe,
    output logic bus_din, bus_chk_in,
    // Bench side
    input wire logic [L-1:0] in_pat,
    input wire logic         chk_flip,
    output logic [L-1:0]     out_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [L-1:0] sr = '0;
    logic [31:0]  chk = '0;

    always @(posedge bus_load or posedge bus_clk) begin
        if (bus_load) begin
            sr <= in_pat;
        end else begin
            sr <= {sr[L-2:0], bus_dout};
        end
    end
    always @(posedge bus_clk) begin
        chk <= {chk[30:0], bus_chk_out};
    end
    always @(posedge bus_strobe) begin
        out_latch <= sr;
    end
    assign bus_din = sr[L-1];
    // The bench may invert the check chain to fake a broken bus.
    assign bus_chk_in = chk[31] ^ chk_flip;
endmodule : sio_chain_model

`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the serial I/O shift bus controller.
// Assumes the chain model beside it and a 20 MHz core clock.
`include "sio_consts.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L = 32;
    logic core_clk = 1'b0, rst = 1'b1, cycle_req = 1'b0, tc_req = 1'b0;
    logic ir_req = 1'b0, int_out_req = 1'b0, img_wr = 1'b0;
    logic img_wdata = 1'b0, img_rd = 1'b0, chk_flip = 1'b0;
    logic [1:0] img_sel = 2'h0;
    logic [9:0] img_addr = 10'h000;
    logic [31:0] in_pat = 32'h0000_0000;
    logic [`SIO_SLOTS*`SIO_SLOT_W-1:0] slot_bits = {`SIO_SLOTS{7'h01}};
    logic cycle_busy, cycle_done, int_out_pending, stop_mode, bus_fault;
    logic io_not_ready_flag, img_rdata, img_rvalid, bus_clk, bus_dout;
    logic bus_din, bus_chk_out, bus_chk_in, bus_load, bus_strobe;
    logic [1:0] cycle_kind;
    logic [31:0] out_latch;
    logic [31:0] v;
    int err_count = 0;
    int cmp_count = 0;

    sio_bus_ctrl uut (.*);
    sio_chain_model #(.L(L)) u_chain (.*);

    initial forever #25 core_clk = ~core_clk;

    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Walks all chain positions of one image table, one access each.
    task automatic img(input logic [1:0] sel, input logic wr,
                       input logic [31:0] wv);
        for (int p = 0; p < L; p++) begin
            @(negedge core_clk);
            img_sel = sel;
            img_addr = p[9:0];
            img_wr = wr;
            img_wdata = wv[p];
            img_rd = !wr;
            @(negedge core_clk);
            img_wr = 1'b0;
            img_rd = 1'b0;
            v[p] = img_rdata;
        end
    endtask : img

    task automatic run(input logic [3:0] r);
        int n;
        int e;
        e = (r[3] || r[2]) ? 501 + L * 500 : 1001 + L * 500;
        @(negedge core_clk);
        {ir_req, tc_req, int_out_req, cycle_req} = r;
        @(negedge core_clk);
        {ir_req, tc_req, int_out_req, cycle_req} = 4'h0;
        n = 1;
        while (cycle_done !== 1'b1 && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        check("cycle time", 32'(n >= e - 2 && n <= e + 2), 32'h1);
    endtask : run

    task automatic t_normal;
        img(2'h1, 1'b1, 32'hC3A5_0F96);
        in_pat = 32'h5A3C_81E7;
        run(4'h1);
        check("kind", 32'(cycle_kind), 32'h0);
        check("out latch", out_latch, 32'hC3A5_0F96);
        img(2'h0, 1'b0, 32'h0);
        check("input table", v, 32'h5A3C_81E7);
        $display("normal cycle test ended");
    endtask : t_normal

    task automatic t_fault;
        chk_flip = 1'b1;
        run(4'h1);
        @(negedge core_clk);
        check("fault", 32'(bus_fault), 32'h1);
        chk_flip = 1'b0;
        $display("check bit test ended");
    endtask : t_fault

    task automatic t_irq;
        in_pat = 32'h9E6D_3B71;
        run(4'h8);
        @(negedge core_clk);
        check("fault", 32'(bus_fault), 32'h0);
        check("kind", 32'(cycle_kind), 32'h2);
        img(2'h2, 1'b0, 32'h0);
        check("irq image", v, 32'h0000_0001);
        $display("interrupt-driven test ended");
    endtask : t_irq

    task automatic t_timed;
        in_pat = 32'h6B2F_D418;
        run(4'h4);
        check("kind", 32'(cycle_kind), 32'h1);
        img(2'h2, 1'b0, 32'h0);
        check("timed image", v, 32'h6B2F_D418);
        $display("time-controlled test ended");
    endtask : t_timed

    task automatic t_int_out;
        @(negedge core_clk);
        int_out_req = 1'b1;
        repeat (3) @(negedge core_clk);
        int_out_req = 1'b0;
        check("busy", 32'(cycle_busy), 32'h0);
        img(2'h3, 1'b1, 32'h1E2D_3C4B);
        check("pending", 32'(int_out_pending), 32'h1);
        run(4'h2);
        check("kind", 32'(cycle_kind), 32'h3);
        check("out latch", out_latch, 32'h1E2D_3C4B);
        img(2'h1, 1'b0, 32'h0);
        check("output table", v, 32'h1E2D_3C4B);
        $display("interrupt output test ended");
    endtask : t_int_out

    task automatic t_stop;
        slot_bits = {{16{7'h10}}, {16{7'h40}}};
        @(negedge core_clk);
        cycle_req = 1'b1;
        repeat (8) @(negedge core_clk);
        cycle_req = 1'b0;
        check("stop", 32'({stop_mode, io_not_ready_flag, bus_load}),
              32'h6);
        $display("overlong chain test ended");
    endtask : t_stop

    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        check("idle", 32'({cycle_busy, stop_mode, bus_load}), 32'h0);
        t_normal;
        t_fault;
        t_irq;
        t_timed;
        t_int_out;
        t_stop;
        give_verdict;
    end

    initial begin
        repeat (99000) @(posedge core_clk);
        err_count++;
        give_verdict;
    end
endmodule : testbench

`default_nettype wire

// ### verilog/sio_buf.sv
// Small FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module sio_buf #(
    parameter int W     = 13,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (count_reg != CW'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ?
                              '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ?
                              '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : sio_buf

`default_nettype wire

// ### verilog/sio_bus_ctrl.sv
// Controller end of the serial I/O shift bus: data cycles, images, check.
// Assumes the slot table is static and the chain pins are synchronous.
`include "sio_consts.svh"
`default_nettype none

module sio_bus_ctrl
    import sio_pkg::*;
(
    // Clock and reset
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    // Cycle requests and status
    input  wire logic                              cycle_req,
    input  wire logic                              tc_req,
    input  wire logic                              ir_req,
    input  wire logic                              int_out_req,
    output logic                                   cycle_busy,
    output logic                                   cycle_done,
    output logic [1:0]                             cycle_kind,
    output logic                                   int_out_pending,
    output logic                                   stop_mode,
    output logic                                   io_not_ready_flag,
    output logic                                   bus_fault,
    // Slot configuration
    input  wire logic [`SIO_SLOTS*`SIO_SLOT_W-1:0] slot_bits,
    // Image table port
    input  wire logic [1:0]                        img_sel,
    input  wire logic [`SIO_POS_W-1:0]             img_addr,
    input  wire logic                              img_wr,
    input  wire logic                              img_wdata,
    input  wire logic                              img_rd,
    output logic                                   img_rdata,
    output logic                                   img_rvalid,
    // Shift chain pins
    output logic                                   bus_clk,
    output logic                                   bus_dout,
    input  wire logic                              bus_din,
    output logic                                   bus_chk_out,
    input  wire logic                              bus_chk_in,
    output logic                                   bus_load,
    output logic                                   bus_strobe
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sio_state_e               state_reg;
    sio_cycle_e               kind_reg;
    logic [`SIO_PH_W-1:0]     ph_reg;
    logic [`SIO_LEN_W-1:0]    step_reg;
    logic [`SIO_LEN_W-1:0]    len_reg;
    logic [`SIO_LEN_W-1:0]    low2_reg;
    logic [`SIO_MAX_BITS-1:0] in_img_reg;
    logic [`SIO_MAX_BITS-1:0] out_img_reg;
    logic [`SIO_MAX_BITS-1:0] iin_img_reg;
    logic [`SIO_MAX_BITS-1:0] iout_img_reg;
    logic                     chk_armed_reg;
    logic                     chk_err_reg;
    logic                     pending_reg;
    logic                     stop_reg;
    logic                     not_ready_reg;
    logic                     fault_reg;
    logic                     done_reg;
    logic                     rdata_reg;
    logic                     rvalid_reg;
    logic                     clk_pin_reg;
    logic                     dout_reg;
    logic                     chk_out_reg;
    logic                     load_reg;
    logic                     strobe_reg;

    logic [`SIO_LEN_W-1:0]    total_len;
    logic [`SIO_LEN_W-1:0]    low2_len;
    logic [`SIO_POS_W-1:0]    pos;
    logic                     bit_end;
    logic                     sample_pt;
    logic                     push_want;
    logic                     push_ready;
    logic                     stall;
    logic [`SIO_BUF_W-1:0]    push_data;
    logic                     pop_valid;
    logic                     pop_ready;
    logic [`SIO_BUF_W-1:0]    pop_data;
    sio_image_e               pop_img;
    logic [`SIO_POS_W-1:0]    pop_pos;
    logic                     any_req;

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    sio_chain_len u_len (
        .slot_bits (slot_bits),
        .total_len (total_len),
        .low2_len  (low2_len)
    );

    sio_buf #(
        .W     (`SIO_BUF_W),
        .DEPTH (`SIO_BUF_DEPTH)
    ) u_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (push_want),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data)
    );

    // ------------------------------------------------------------------
    // Bit timing and capture selection
    // ------------------------------------------------------------------
    assign bit_end   = (ph_reg == `SIO_PH_W'(`SIO_BIT_CYC - 1));
    assign sample_pt = (ph_reg == `SIO_PH_W'(`SIO_HALF_CYC - 1));
    // Position counts back from the far end of the chain.
    assign pos = `SIO_POS_W'(len_reg - step_reg - 1'b1);
    assign any_req = cycle_req || tc_req || ir_req ||
                     (int_out_req && pending_reg);

    always_comb begin
        push_want = 1'b0;
        push_data = {IMG_IN, pos, bus_din};
        if (state_reg == ST_SHIFT && sample_pt) begin
            case (kind_reg)
                CYC_NORMAL: begin
                    push_want = 1'b1;
                end
                CYC_INT_TC: begin
                    push_want = 1'b1;
                    push_data = {IMG_INT_IN, pos, bus_din};
                end
                CYC_INT_IR: begin
                    push_want = (`SIO_LEN_W'(pos) < low2_reg);
                    push_data = {IMG_INT_IN, pos, bus_din};
                end
                default: begin
                    push_want = 1'b1;
                    push_data = {IMG_OUT, pos, iout_img_reg[pos]};
                end
            endcase
        end
    end

    // A full buffer holds the bit clock until it drains into the image tables.
    assign stall = push_want && !push_ready;

    // ------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            kind_reg  <= CYC_NORMAL;
            ph_reg    <= '0;
            step_reg  <= '0;
            len_reg   <= '0;
            low2_reg  <= '0;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    ph_reg   <= '0;
                    step_reg <= '0;
                    len_reg  <= total_len;
                    low2_reg <= low2_len;
                    if (any_req) begin
                        if (total_len > `SIO_LEN_W'(`SIO_MAX_BITS)) begin
                            state_reg <= ST_STOP;
                        end else begin
                            state_reg <= ST_LOAD;
                        end
                        if (ir_req) begin
                            kind_reg <= CYC_INT_IR;
                        end else if (tc_req) begin
                            kind_reg <= CYC_INT_TC;
                        end else if (int_out_req && pending_reg) begin
                            kind_reg <= CYC_INT_OUT;
                        end else begin
                            kind_reg <= CYC_NORMAL;
                        end
                    end
                end
                ST_LOAD: begin
                    ph_reg <= bit_end ? '0 : ph_reg + 1'b1;
                    if (bit_end) begin
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (!stall) begin
                        ph_reg <= bit_end ? '0 : ph_reg + 1'b1;
                    end
                    if (bit_end) begin
                        step_reg <= step_reg + 1'b1;
                        // The whole chain is always shifted.
                        if (step_reg == len_reg - 1'b1) begin
                            if (kind_reg == CYC_NORMAL ||
                                kind_reg == CYC_INT_OUT) begin
                                state_reg <= ST_STROBE;
                            end else begin
                                state_reg <= ST_IDLE;
                                done_reg  <= 1'b1;
                            end
                        end
                    end
                end
                ST_STROBE: begin
                    ph_reg <= bit_end ? '0 : ph_reg + 1'b1;
                    if (bit_end) begin
                        state_reg <= ST_IDLE;
                        done_reg  <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_STOP;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Chain pins
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_pin_reg <= 1'b0;
            dout_reg    <= 1'b0;
            chk_out_reg <= 1'b0;
            load_reg    <= 1'b0;
            strobe_reg  <= 1'b0;
        end else begin
            load_reg   <= (state_reg == ST_LOAD);
            strobe_reg <= (state_reg == ST_STROBE);
            if (state_reg == ST_SHIFT) begin
                clk_pin_reg <= (ph_reg >= `SIO_PH_W'(`SIO_HALF_CYC));
                if (ph_reg == '0) begin
                    dout_reg <= (kind_reg == CYC_INT_OUT) ? iout_img_reg[pos]
                                                          : out_img_reg[pos];
                    // Alternating pattern from the low bit of the step count; chain length may be odd.
                    chk_out_reg <= step_reg[0];
                end
            end else begin
                clk_pin_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus monitoring
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chk_armed_reg <= 1'b0;
            chk_err_reg   <= 1'b0;
            fault_reg     <= 1'b0;
        end else begin
            fault_reg <= 1'b0;
            if (state_reg == ST_LOAD) begin
                chk_err_reg <= 1'b0;
            end else if (state_reg == ST_SHIFT && sample_pt &&
                         chk_armed_reg && bus_chk_in != step_reg[0]) begin
                chk_err_reg <= 1'b1;
            end
            if (done_reg) begin
                chk_armed_reg <= 1'b1;
                fault_reg     <= chk_err_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pending_reg   <= 1'b0;
            stop_reg      <= 1'b0;
            not_ready_reg <= 1'b0;
        end else begin
            if (img_wr && img_sel == IMG_INT_OUT) begin
                pending_reg <= 1'b1;
            end else if (state_reg == ST_IDLE && !ir_req && !tc_req &&
                         int_out_req && pending_reg) begin
                pending_reg <= 1'b0;
            end
            if (state_reg == ST_STOP) begin
                stop_reg      <= 1'b1;
                not_ready_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Image tables
    // ------------------------------------------------------------------
    // User access owns the tables in its cycle; the buffer waits.
    assign pop_ready = !(img_wr || img_rd);
    assign pop_img   = sio_image_e'(pop_data[`SIO_BUF_W-1 -: 2]);
    assign pop_pos   = pop_data[`SIO_POS_W:1];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_img_reg   <= '0;
            out_img_reg  <= '0;
            iin_img_reg  <= '0;
            iout_img_reg <= '0;
        end else if (pop_valid && pop_ready) begin
            case (pop_img)
                IMG_IN:     in_img_reg[pop_pos]  <= pop_data[0];
                IMG_OUT:    out_img_reg[pop_pos] <= pop_data[0];
                default:    iin_img_reg[pop_pos] <= pop_data[0];
            endcase
        end else if (img_wr) begin
            case (img_sel)
                IMG_IN:     in_img_reg[img_addr]   <= img_wdata;
                IMG_OUT:    out_img_reg[img_addr]  <= img_wdata;
                IMG_INT_IN: iin_img_reg[img_addr]  <= img_wdata;
                default:    iout_img_reg[img_addr] <= img_wdata;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg  <= 1'b0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= img_rd;
            if (img_rd) begin
                case (img_sel)
                    IMG_IN:     rdata_reg <= in_img_reg[img_addr];
                    IMG_OUT:    rdata_reg <= out_img_reg[img_addr];
                    IMG_INT_IN: rdata_reg <= iin_img_reg[img_addr];
                    default:    rdata_reg <= iout_img_reg[img_addr];
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cycle_busy        = (state_reg != ST_IDLE);
    assign cycle_done        = done_reg;
    assign cycle_kind        = kind_reg;
    assign int_out_pending   = pending_reg;
    assign stop_mode         = stop_reg;
    assign io_not_ready_flag = not_ready_reg;
    assign bus_fault         = fault_reg;
    assign img_rdata         = rdata_reg;
    assign img_rvalid        = rvalid_reg;
    assign bus_clk           = clk_pin_reg;
    assign bus_dout          = dout_reg;
    assign bus_chk_out       = chk_out_reg;
    assign bus_load          = load_reg;
    assign bus_strobe        = strobe_reg;

endmodule : sio_bus_ctrl

`default_nettype wire

// ### verilog/sio_chain_len.sv
// Chain length from the per-slot data bit counts.
// Assumes the slot table is held stable while a cycle runs.
`include "sio_consts.svh"
`default_nettype none

module sio_chain_len (
    // Per-slot data bits, slot 0 in the low field
    input  wire logic [`SIO_SLOTS*`SIO_SLOT_W-1:0] slot_bits,
    // Sums
    output logic [`SIO_LEN_W-1:0]                 total_len,
    output logic [`SIO_LEN_W-1:0]                 low2_len
);
    logic [`SIO_LEN_W-1:0] run [`SIO_SLOTS+1];

    assign run[0] = '0;

    // A slot reporting zero bits still holds its default four stages.
    genvar g;
    generate
        for (g = 0; g < `SIO_SLOTS; g++) begin : g_sum
            logic [`SIO_SLOT_W-1:0] w;
            assign w = slot_bits[g*`SIO_SLOT_W +: `SIO_SLOT_W];
            assign run[g+1] = run[g] + ((w == '0)
                ? `SIO_LEN_W'(`SIO_STAGE_BITS)
                : `SIO_LEN_W'(w));
        end
    endgenerate

    assign total_len = run[`SIO_SLOTS];
    assign low2_len  = run[2];

endmodule : sio_chain_len

`default_nettype wire

// ### verilog/sio_consts.svh
// Constants for the serial I/O shift bus controller.
// Assumes a 20 MHz core clock; included by its bare name.
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

// ----------------------------------------------------------------------
// Chain geometry
// ----------------------------------------------------------------------
`define SIO_SLOTS       32
`define SIO_SLOT_W      7
`define SIO_STAGE_BITS  4
`define SIO_MAX_BITS    704
`define SIO_POS_W       10
`define SIO_LEN_W       12

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SIO_CLK_NS      50
`define SIO_BIT_NS      25000
`define SIO_BIT_CYC     ((`SIO_BIT_NS + `SIO_CLK_NS - 1) / `SIO_CLK_NS)
`define SIO_HALF_CYC    (`SIO_BIT_CYC / 2)
`define SIO_PH_W        9

// ----------------------------------------------------------------------
// Data buffer
// ----------------------------------------------------------------------
`define SIO_BUF_W       13
`define SIO_BUF_DEPTH   2

`endif

// ### verilog/sio_pkg.sv
// Types shared by the serial I/O shift bus controller.
// Assumes nothing of its surroundings.
`default_nettype none

package sio_pkg;

    typedef enum {
        ST_IDLE,
        ST_LOAD,
        ST_SHIFT,
        ST_STROBE,
        ST_STOP
    } sio_state_e;

    typedef enum logic [1:0] {
        CYC_NORMAL,
        CYC_INT_TC,
        CYC_INT_IR,
        CYC_INT_OUT
    } sio_cycle_e;

    typedef enum logic [1:0] {
        IMG_IN,
        IMG_OUT,
        IMG_INT_IN,
        IMG_INT_OUT
    } sio_image_e;

endpackage : sio_pkg

`default_nettype wire
